/* File: lhip_pkg.sv */
package lhip_pkg;

   // ****************************************************************
   // Register offsets of the APB slave.
   // ****************************************************************
   localparam logic [7:0] OFS_PORT   = 8'h00;
   localparam logic [7:0] OFS_DATA   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MODE   = 8'h0C;

   // ****************************************************************
   // Field positions.
   // ****************************************************************
   localparam int PORT_RS_BIT  = 8;
   localparam int PORT_RW_BIT  = 9;
   localparam int ST_BUSY_BIT  = 0;
   localparam int ST_NIB_BIT   = 1;
   localparam int ST_CG_BIT    = 2;
   localparam int ST_INIT_BIT  = 3;

   // ****************************************************************
   // Reset values and fixed codes.
   // ****************************************************************
   localparam logic [7:0] CMD_CLEAR   = 8'h01;
   localparam logic [7:0] SPACE_CODE  = 8'h20;
   localparam logic [6:0] DD_LAST_1L  = 7'h4F;
   localparam logic [6:0] DD_LAST_L1  = 7'h27;
   localparam logic [6:0] DD_FIRST_L2 = 7'h40;
   localparam logic [6:0] DD_LAST_L2  = 7'h67;

   // ****************************************************************
   // Timing: oscillator rate and execution times.
   // ****************************************************************
   localparam longint CLK_HZ       = 200_000_000;
   localparam longint OSC_HZ       = 320_000;
   localparam longint LONG_EXEC_NS = 1_280_000;
   localparam longint SHORT_EXEC_NS = 31_000;
   localparam longint ADD_DELAY_NS = 4_700;
   localparam longint INIT_STD_NS  = 15_000_000;
   localparam longint INIT_LOW_NS  = 40_000_000;
   localparam longint CLK_PER_OSC  = CLK_HZ / OSC_HZ;
   // Oscillator cycles per execution time (rounded down, longest time).
   localparam longint LONG_OSC     = LONG_EXEC_NS * OSC_HZ / 1_000_000_000;
   localparam longint SHORT_OSC    = SHORT_EXEC_NS * OSC_HZ / 1_000_000_000;
   localparam longint ADD_CYC      = ADD_DELAY_NS * CLK_HZ / 1_000_000_000;
   localparam longint INIT_STD_CYC = INIT_STD_NS * CLK_HZ / 1_000_000_000;
   localparam longint INIT_LOW_CYC = INIT_LOW_NS * CLK_HZ / 1_000_000_000;

   typedef struct packed {
      logic       display_on;
      logic       cursor_on;
      logic       blink_on;
      logic       increment;
      logic       shift_en;
      logic       width8;
      logic       two_lines;
      logic       font_5x10;
   } lhip_cfg_t;

   typedef enum {
      ST_INIT, ST_IDLE, ST_EXEC, ST_CLEAR, ST_ADDWAIT
   } lhip_state_t;

endpackage

/* File: lhip_core.sv */
`timescale 1ns/1ps
module lhip_core
   import lhip_pkg::*;
#(
   parameter int INIT_CYC = int'(INIT_STD_CYC),
   parameter int CPO      = int'(CLK_PER_OSC)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [6:0]       disp_shift,
   output lhip_cfg_t        cfg
);

   // ****************************************************************
   // Internal state.
   // ****************************************************************
   logic [7:0]  dd_ram_q [0:79];
   logic [7:0]  cg_ram_q [0:63];
   logic [6:0]  ac_q;
   logic        cg_sel_q;
   logic        nib_low_q;
   logic [3:0]  nib_hold_q;
   logic [7:0]  rd_latch_q;
   logic        busy_q;
   logic        ac_pend_q;
   logic        ac_up_q;
   logic        ac_pend_rd_q;
   logic [31:0] tmr_q;
   logic [6:0]  clr_idx_q;
   logic [6:0]  shift_q;
   logic [31:0] init_len_q;
   lhip_cfg_t   cfg_q;
   lhip_state_t state_q;

   wire acc     = psel & penable;
   wire wr      = acc & pwrite;
   wire rd      = acc & ~pwrite;
   wire port_a  = (paddr == OFS_PORT);
   wire data_a  = (paddr == OFS_DATA);
   wire st_a    = (paddr == OFS_STATUS);
   wire mode_a  = (paddr == OFS_MODE);
   wire known_a = port_a | data_a | st_a | mode_a;

   assign pready  = 1'b1;
   assign pslverr = acc & ~known_a;
   assign cfg     = cfg_q;
   assign disp_shift = shift_q;

   // One host operation on the pins: select, direction and a data byte or nibble.
   wire       op_rs   = pwdata[PORT_RS_BIT];
   wire       op_rw   = pwdata[PORT_RW_BIT];
   wire       op_go   = wr & port_a;
   wire       wide    = cfg_q.width8;
   // Upper lines carry the nibble; lower four are ignored in narrow mode.
   wire [3:0] nib_in  = pwdata[7:4];
   wire       last_op = wide | nib_low_q;
   wire [7:0] byte_in = wide ? pwdata[7:0] : {nib_hold_q, nib_in};
   wire       done_wr = op_go & ~op_rw & last_op;
   wire       done_rd = op_go & op_rw & last_op;
   wire       ir_wr   = done_wr & ~op_rs & ~busy_q;
   wire       dr_wr   = done_wr & op_rs & ~busy_q;
   wire       dr_rd   = done_rd & op_rs & ~busy_q;

   function automatic logic [6:0] step(input logic [6:0] a, input logic up);
      step = up ? a + 7'd1 : a - 7'd1;
   endfunction

   function automatic logic [31:0] osc_cyc(input longint n);
      osc_cyc = 32'(n * CPO);
   endfunction

   // Second-line addresses share the upper half of the storage in two-line mode.
   function automatic logic [6:0] dd_idx(input logic [6:0] a, input logic two);
      dd_idx = (two && a >= DD_FIRST_L2) ? a - DD_FIRST_L2 + 7'd40 : a;
   endfunction

   // An instruction write or data access that arrives while a counter step is pending takes that step first,
   // so the operation works on the counter that software expects, except a narrow-mode data read, latched at the first nibble.
   wire       new_op      = ir_wr | dr_wr | dr_rd;
   wire       ac_step_now = (state_q == ST_ADDWAIT) && ((tmr_q <= 32'd1) || new_op);
   wire [6:0] ac_stepped  = step(ac_q, ac_up_q);
   wire [6:0] ac_cur      = !ac_step_now ? ac_q :
                            (cg_sel_q ? {1'b0, ac_stepped[5:0]} : ac_stepped);

   // ****************************************************************
   // Nibble sequencing.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nib_low_q  <= 1'b0;
         nib_hold_q <= 4'h0;
      end else if (op_go && !wide) begin
         nib_low_q  <= ~nib_low_q;
         if (!nib_low_q) begin
            nib_hold_q <= nib_in;
         end
      end else if (wide) begin
         nib_low_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Read latch: the full byte is captured on the first nibble read.
   // ****************************************************************
   wire [7:0] ram_rd = cg_sel_q ? cg_ram_q[ac_cur[5:0]] :
                       dd_ram_q[dd_idx(ac_cur, cfg_q.two_lines)];
   wire [7:0] rd_src = op_rs ? ram_rd : {busy_q, ac_q};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_latch_q <= 8'h00;
      end else if (op_go && op_rw && (wide || !nib_low_q)) begin
         rd_latch_q <= rd_src;
      end
   end

   // ****************************************************************
   // APB read mux.
   // ****************************************************************
   always_comb begin
      prdata = 32'h0000_0000;
      if (port_a || data_a) begin
         if (wide) begin
            prdata[7:0] = rd_latch_q;
         end else if (nib_low_q) begin
            prdata[7:0] = {rd_latch_q[7:4], 4'h0};
         end else begin
            prdata[7:0] = {rd_latch_q[3:0], 4'h0};
         end
      end else if (st_a) begin
         prdata[ST_BUSY_BIT] = busy_q;
         prdata[ST_NIB_BIT]  = nib_low_q;
         prdata[ST_CG_BIT]   = cg_sel_q;
         prdata[ST_INIT_BIT] = (state_q == ST_INIT);
      end else if (mode_a) begin
         prdata[7:0] = cfg_q;
      end
   end

   // ****************************************************************
   // Sequencer and busy timer.
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ST_INIT;
         busy_q     <= 1'b1;
         tmr_q      <= 32'h0000_0000;
         ac_pend_q  <= 1'b0;
         ac_up_q    <= 1'b1;
         clr_idx_q  <= 7'h00;
         init_len_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            ST_INIT: begin
               busy_q <= 1'b1;
               tmr_q  <= tmr_q + 32'd1;
               clr_idx_q <= (clr_idx_q == DD_LAST_1L) ? 7'h00 : clr_idx_q + 7'd1;
               if (tmr_q >= 32'(INIT_CYC - 1)) begin
                  state_q <= ST_IDLE;
                  busy_q  <= 1'b0;
                  tmr_q   <= 32'h0000_0000;
               end
            end
            ST_IDLE, ST_ADDWAIT: begin
               if (state_q == ST_ADDWAIT) begin
                  tmr_q <= tmr_q - 32'd1;
                  if (ac_step_now) begin
                     ac_pend_q <= 1'b0;
                     state_q   <= ST_IDLE;
                  end
               end
               if (ir_wr) begin
                  busy_q <= 1'b1;
                  if (byte_in[7:1] == 7'h00 && byte_in[0]) begin
                     state_q   <= ST_CLEAR;
                     clr_idx_q <= 7'h00;
                     tmr_q     <= osc_cyc(LONG_OSC);
                  end else if (byte_in[7:1] == 7'h01) begin
                     state_q <= ST_EXEC;
                     tmr_q   <= osc_cyc(LONG_OSC);
                  end else begin
                     state_q <= ST_EXEC;
                     tmr_q   <= osc_cyc(SHORT_OSC);
                  end
               end else if (dr_wr || dr_rd) begin
                  busy_q    <= 1'b1;
                  state_q   <= ST_EXEC;
                  tmr_q     <= osc_cyc(SHORT_OSC);
                  ac_pend_q <= 1'b1;
                  ac_up_q   <= cfg_q.increment;
               end
            end
            ST_CLEAR: begin
               clr_idx_q <= clr_idx_q + 7'd1;
               tmr_q     <= tmr_q - 32'd1;
               if (clr_idx_q == DD_LAST_1L) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               tmr_q <= tmr_q - 32'd1;
               if (tmr_q <= 32'd1) begin
                  busy_q <= 1'b0;
                  tmr_q  <= 32'(ADD_CYC);
                  state_q <= ac_pend_q ? ST_ADDWAIT : ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Configuration, address counter and shift.
   // ****************************************************************
   // Reads do not shift the display, nor does character RAM access.
   wire       shift_step = ac_step_now && !cg_sel_q && cfg_q.shift_en && !ac_pend_rd_q;
   wire [6:0] shift_cur  = shift_step ? step(shift_q, ~ac_up_q) : shift_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= '{default: 1'b0, width8: 1'b1, increment: 1'b1};
         ac_q     <= 7'h00;
         cg_sel_q <= 1'b0;
         shift_q  <= 7'h00;
      end else if (ac_step_now && !ir_wr) begin
         ac_q    <= ac_cur;
         shift_q <= shift_cur;
      end else if (ir_wr) begin
         ac_q    <= ac_cur;
         shift_q <= shift_cur;
         casez (byte_in)
            8'b0000_0001: begin
               ac_q     <= 7'h00;
               cg_sel_q <= 1'b0;
               shift_q  <= 7'h00;
               cfg_q.increment <= 1'b1;
            end
            8'b0000_001?: begin
               ac_q     <= 7'h00;
               cg_sel_q <= 1'b0;
               shift_q  <= 7'h00;
            end
            8'b0000_01??: begin
               cfg_q.increment <= byte_in[1];
               cfg_q.shift_en  <= byte_in[0];
            end
            8'b0000_1???: begin
               cfg_q.display_on <= byte_in[2];
               cfg_q.cursor_on  <= byte_in[1];
               cfg_q.blink_on   <= byte_in[0];
            end
            8'b0001_????: begin
               if (byte_in[3]) begin
                  shift_q <= step(shift_cur, byte_in[2]);
               end else begin
                  ac_q <= step(ac_cur, byte_in[2]);
               end
            end
            8'b001?_????: begin
               cfg_q.width8    <= byte_in[4];
               cfg_q.two_lines <= byte_in[3];
               cfg_q.font_5x10 <= byte_in[2];
            end
            8'b01??_????: begin
               ac_q     <= {1'b0, byte_in[5:0]};
               cg_sel_q <= 1'b1;
            end
            8'b1???_????: begin
               ac_q     <= byte_in[6:0];
               cg_sel_q <= 1'b0;
            end
            default: begin
               ac_q <= ac_q;
            end
         endcase
      end
   end

   // Remembers whether the pending counter step belongs to a read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ac_pend_rd_q <= 1'b0;
      end else if (dr_wr || dr_rd) begin
         ac_pend_rd_q <= dr_rd;
      end
   end

   // ****************************************************************
   // RAM storage.
   // ****************************************************************
   wire dd_ok = cfg_q.two_lines ?
                (ac_cur <= DD_LAST_L1 || (ac_cur >= DD_FIRST_L2 && ac_cur <= DD_LAST_L2)) :
                (ac_cur <= DD_LAST_1L);

   always_ff @(posedge pclk) begin
      if (state_q == ST_CLEAR || state_q == ST_INIT) begin
         dd_ram_q[clr_idx_q] <= SPACE_CODE;
      end else if (dr_wr && !cg_sel_q && dd_ok) begin
         dd_ram_q[dd_idx(ac_cur, cfg_q.two_lines)] <= byte_in;
      end
   end

   always_ff @(posedge pclk) begin
      if (dr_wr && cg_sel_q) begin
         cg_ram_q[ac_cur[5:0]] <= byte_in;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   AST_INIT_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_INIT) |-> busy_q) else $error("busy low during init");
   AST_REFUSE: assert property (@(posedge pclk) disable iff (!presetn)
      (busy_q && op_go && !op_rw) |=> $stable(cfg_q)) else $error("write taken while busy");
   AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      (ir_wr && byte_in == CMD_CLEAR) |=> (ac_q == 7'h00 && cfg_q.increment))
      else $error("clear failed");
   AST_NIB: assert property (@(posedge pclk) disable iff (!presetn)
      (op_go && !wide && nib_low_q) |=> !nib_low_q) else $error("nibble pointer stuck");
   AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
      ac_step_now && !cg_sel_q && !ir_wr |=> ac_q == step($past(ac_q), $past(ac_up_q)))
      else $error("counter step wrong");
   AST_ADD_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(busy_q) && ac_pend_q && !new_op |=> $stable(ac_q))
      else $error("counter stepped early");
   AST_FUNC: assert property (@(posedge pclk) disable iff (!presetn)
      (ir_wr && byte_in[7:5] == 3'b001) |=> cfg_q.width8 == $past(byte_in[4]))
      else $error("function set lost");
   AST_DDADDR: assert property (@(posedge pclk) disable iff (!presetn)
      (ir_wr && byte_in[7]) |=> (ac_q == $past(byte_in[6:0]) && !cg_sel_q))
      else $error("display address load wrong");
   AST_NIB_READ: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && port_a && !wide && nib_low_q) |-> prdata[7:4] == rd_latch_q[7:4])
      else $error("high nibble not returned first");

endmodule

/* File: lhip_host.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus-side host model: one APB transfer per call.
// ****************************************************************
module lhip_host (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // Released address and data lines show the inverse so stale values never look valid.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~wd;
   endtask
endmodule

/* File: lcd_host_instruction_port_bench.sv */
`timescale 1ns/1ps
module lcd_host_instruction_port_bench;
   import lhip_pkg::*;
   typedef struct packed {
      logic [31:0] val;
      logic [31:0] msk;
      logic        err;
   } lhip_note_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, rnd;
   logic [31:0] pwdata, prdata;
   logic [6:0]  disp_shift;
   lhip_cfg_t   cfg;
   lhip_note_t  notes[$];
   lhip_note_t  mon_note;
   int          failures = 0;
   int          checks_done = 0;
   int          cyc = 0;
   localparam int ADDW = int'(ADD_CYC);
   logic [7:0] cmds [8] = '{8'h38, 8'h0F, 8'h06, 8'h05, 8'h0A, 8'h34, 8'h38, 8'h06};
   logic [7:0] cfgs [8] = '{8'h16, 8'hF6, 8'hF6, 8'hEE, 8'h4E, 8'h4D, 8'h4E, 8'h56};

   lhip_core #(.INIT_CYC(100), .CPO(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .disp_shift(disp_shift), .cfg(cfg));
   lhip_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ****************************************************************
   // Clock, cycle count and shared tasks.
   // ****************************************************************
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) if (presetn) cyc <= cyc + 1;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                     input logic err);
      logic [31:0] d;
      logic e;
      notes.push_back('{exp & m, m, err});
      host_u.xfer(1'b0, a, 32'h0000_0000, d, e);
   endtask
   task automatic op(input logic rs, input logic rw, input logic [7:0] b);
      logic [31:0] d;
      logic e;
      host_u.xfer(1'b1, OFS_PORT, {22'h0, rw, rs, b}, d, e);
   endtask
   task automatic wait_idle();
      logic [31:0] d;
      logic e;
      int n = 0;
      do begin
         notes.push_back('{32'h0000_0000, 32'h0000_0000, 1'b0});
         host_u.xfer(1'b0, OFS_STATUS, 32'h0000_0000, d, e);
         n++;
      end while (d[ST_BUSY_BIT] !== 1'b0 && n < 3000);
      if (n >= 3000) check("idle wait", 32'h0000_0001, 32'h0000_0000);
   endtask
   task automatic instr(input logic [7:0] b);
      op(1'b0, 1'b0, b);
      rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0001, 1'b0);
      wait_idle();
   endtask
   task automatic ac_read(input logic [6:0] a);
      op(1'b0, 1'b1, 8'h00);
      rd(OFS_PORT, {25'h0, a}, 32'h0000_00FF, 1'b0);
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (notes.size() == 0) check("unexpected read", 32'h0000_0001, 32'h0000_0000);
         else begin
            mon_note = notes.pop_front();
            if (mon_note.msk !== 32'h0000_0000) check("read data", prdata & mon_note.msk, mon_note.val);
            check("slave error", {31'h0, pslverr}, {31'h0, mon_note.err});
         end
      end
   end

   initial begin
      #500_000;
      failures++;
      print_verdict();
   end

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      presetn = 1'b0;
      void'($urandom(44723));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_STATUS, 32'h0000_0009, 32'h0000_0009, 1'b0);
      wait_idle();
      check("init length", {31'h0, cyc >= 99}, 32'h0000_0001);
      rd(OFS_MODE, 32'h0000_0014, 32'h0000_00FF, 1'b0);
      check("cfg port", {24'h0, cfg}, 32'h0000_0014);
      ac_read(7'h00);
      op(1'b1, 1'b1, 8'h00);
      wait_idle();
      rd(OFS_PORT, {24'h0, SPACE_CODE}, 32'h0000_00FF, 1'b0);
      for (int i = 0; i < 8; i++) begin
         instr(cmds[i]);
         rd(OFS_MODE, {24'h0, cfgs[i]}, 32'h0000_00FF, 1'b0);
      end
      op(1'b0, 1'b0, 8'h0C);
      op(1'b0, 1'b0, 8'h08);
      wait_idle();
      rd(OFS_MODE, 32'h0000_0096, 32'h0000_00FF, 1'b0);
      rnd = 8'($urandom());
      instr(8'hC5);
      ac_read(7'h45);
      op(1'b1, 1'b0, rnd);
      wait_idle();
      ac_read(7'h45);
      repeat (ADDW + 20) @(posedge pclk);
      ac_read(7'h46);
      instr(8'hC5);
      op(1'b1, 1'b1, 8'h00);
      wait_idle();
      rd(OFS_PORT, {24'h0, rnd}, 32'h0000_00FF, 1'b0);
      instr(8'h04);
      op(1'b1, 1'b1, 8'h00);
      wait_idle();
      repeat (ADDW + 20) @(posedge pclk);
      ac_read(7'h45);
      instr(8'h7F);
      rd(OFS_STATUS, 32'h0000_0004, 32'h0000_0004, 1'b0);
      ac_read(7'h3F);
      instr(8'hC5);
      instr(8'h14);
      ac_read(7'h46);
      instr(8'h1C);
      ac_read(7'h46);
      check("shifted", {31'h0, disp_shift != 7'h00}, 32'h0000_0001);
      instr(8'h02);
      ac_read(7'h00);
      check("shift home", {25'h0, disp_shift}, 32'h0000_0000);
      instr(8'h05);
      instr(8'hC5);
      instr(8'h01);
      rd(OFS_MODE, 32'h0000_0018, 32'h0000_0018, 1'b0);
      ac_read(7'h00);
      instr(8'h28);
      op(1'b0, 1'b0, 8'hCA);
      rd(OFS_STATUS, 32'h0000_0002, 32'h0000_0003, 1'b0);
      op(1'b0, 1'b0, 8'h55);
      wait_idle();
      op(1'b0, 1'b1, 8'h00);
      rd(OFS_PORT, 32'h0000_0040, 32'h0000_00F0, 1'b0);
      op(1'b0, 1'b1, 8'h00);
      rd(OFS_PORT, 32'h0000_0050, 32'h0000_00F0, 1'b0);
      rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0002, 1'b0);
      op(1'b0, 1'b0, 8'h3F);
      op(1'b0, 1'b0, 8'h80);
      wait_idle();
      rd(OFS_MODE, 32'h0000_0004, 32'h0000_0004, 1'b0);
      rd(8'h10, 32'h0000_0000, 32'h0000_0000, 1'b1);
      print_verdict();
   end
endmodule
